// ### nvsram_seq_defines.svh
`ifndef NVSRAM_SEQ_DEFINES_SVH
`define NVSRAM_SEQ_DEFINES_SVH
`define SEQ_ADDR_0     14'h0E38
`define SEQ_ADDR_1     14'h31C7
`define SEQ_ADDR_2     14'h03E0
`define SEQ_ADDR_3     14'h3C1F
`define SEQ_ADDR_4     14'h303F
`define SEQ_LAST_STORE 14'h0FC0
`define SEQ_LAST_RECAL 14'h0C63
`define SEQ_LAST_ASDIS 14'h03F8
`define SEQ_LAST_ASEN  14'h07F0
`define CLK_PERIOD_NS  50
`define STORE_TIME_NS  8000000
`define RECALL_TIME_NS 200000
`define STORE_CYCLES   ((`STORE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECALL_CYCLES  ((`RECALL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYCLES  2
`endif

// ### nvsram_seq_pkg.sv
package nvsram_seq_pkg;
  // commands the user may ask for
  typedef enum logic [2:0] {
    cmd_read    = 3'h0,
    cmd_write   = 3'h1,
    cmd_store   = 3'h2,
    cmd_recall  = 3'h3,
    cmd_as_off  = 3'h4,
    cmd_as_on   = 3'h5
  } cmd_e;
  // bus cycle phases, gray from idle through to wait
  typedef enum logic [2:0] {
    ph_idle   = 3'b000,
    ph_setup  = 3'b001,
    ph_strobe = 3'b011,
    ph_end    = 3'b010,
    ph_wait   = 3'b110
  } phase_e;
endpackage

// ### nvsram_bus_cycle.sv
`timescale 1ns/1ps
`include "nvsram_seq_defines.svh"
// one asynchronous read or write cycle on the pins
module nvsram_bus_cycle
  import nvsram_seq_pkg::*;
#(
  parameter int STROBE = `STROBE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic        use_oe,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  dq_in,
  output logic             done,
  output logic [7:0]       rdata,
  output logic [14:0]      addr_pin,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  output logic [7:0]       dq_out,
  output logic             dq_oe
);
  phase_e     phase;   // cycle phase
  logic [3:0] cnt;     // strobe width counter
  logic [7:0] dq_s1;   // pin sampler stages
  logic [7:0] dq_s2;
  logic [7:0] dq_s3;

  // three-stage sampler for the async data pins
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      dq_s3 <= 8'h00;
    end else if (clk_en) begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
    end
  end

  // cycle sequencer: address first, then strobes, then release
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase    <= ph_idle;
      cnt      <= 4'h0;
      done     <= 1'b0;
      rdata    <= 8'h00;
      addr_pin <= 15'h0000;
      ce_n     <= 1'b1;   // deselected
      we_n     <= 1'b1;
      oe_n     <= 1'b1;
      dq_out   <= 8'h00;
      dq_oe    <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      case (phase)
        ph_idle: begin
          if (start) begin
            addr_pin <= addr;   // address stable before strobes
            dq_out   <= wdata;
            dq_oe    <= is_write;
            phase    <= ph_setup;
          end
        end
        ph_setup: begin
          ce_n  <= 1'b0;
          we_n  <= ~dq_oe;       // write keeps oe high
          oe_n  <= dq_oe | ~use_oe;
          cnt   <= 4'(STROBE);
          phase <= ph_strobe;
        end
        ph_strobe: begin
          if (cnt == 4'h0) begin
            phase <= ph_end;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ph_end: begin
          // ce rising ends the cycle and clocks the sequence step
          if (dq_s2 == dq_s3) begin
            rdata <= dq_s3;
          end
          ce_n  <= 1'b1;
          we_n  <= 1'b1;
          oe_n  <= 1'b1;
          phase <= ph_wait;
        end
        ph_wait: begin
          dq_oe <= 1'b0;     // release after strobes are high
          done  <= 1'b1;
          phase <= ph_idle;
        end
        default: phase <= ph_idle;
      endcase
    end
  end
endmodule // nvsram_bus_cycle

// ### nvsram_host.sv
`timescale 1ns/1ps
`include "nvsram_seq_defines.svh"
// host controller: plain accesses and six-read command sequences
module nvsram_host
  import nvsram_seq_pkg::*;
#(
  parameter int STORE_WAIT  = `STORE_CYCLES,
  parameter int RECALL_WAIT = `RECALL_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        req,
  input  wire logic [2:0]  cmd,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        use_oe,
  output logic             busy,
  output logic             ack,
  output logic [7:0]       rdata,
  output logic             autosave_dirty,
  output logic [14:0]      addr_pin,
  output logic             ce_n,
  output logic             we_n,
  output logic             oe_n,
  output logic [7:0]       dq_out,
  output logic             dq_oe,
  input  wire logic [7:0]  dq_in
);
  logic        cyc_start;   // pulse to bus engine
  logic        cyc_write;   // current cycle is a write
  logic [14:0] cyc_addr;    // current cycle address
  logic [7:0]  cyc_wdata;   // current write data
  logic        cyc_done;    // bus engine finished
  logic [7:0]  cyc_rdata;   // captured read byte
  logic        cyc_oe;      // drive oe during this cycle
  logic        in_flight;   // bus cycle outstanding
  logic [2:0]  step;        // current sequence step, 0..5
  logic        in_seq;      // running a sequence
  logic [2:0]  cur_cmd;     // latched command
  logic [22:0] wait_cnt;    // store or recall hold-off
  logic        hold_on;     // hold-off still counting
  logic        hold_end;    // last cycle of the hold-off
  logic        step_done;   // a launched cycle just finished
  logic        seq_final;   // sixth sequence step just finished
  logic        seq_next;    // launch the following sequence step
  logic        plain_cmd;   // read or write, not a sequence
  logic        take;        // request accepted at this edge

  // step address: prefix then command-specific last address
  function automatic logic [13:0] seq_addr(input logic [2:0] s, input logic [2:0] c);
    case (s)
      3'h0:    seq_addr = `SEQ_ADDR_0;
      3'h1:    seq_addr = `SEQ_ADDR_1;
      3'h2:    seq_addr = `SEQ_ADDR_2;
      3'h3:    seq_addr = `SEQ_ADDR_3;
      3'h4:    seq_addr = `SEQ_ADDR_4;
      default: begin
        case (c)
          cmd_store:  seq_addr = `SEQ_LAST_STORE;
          cmd_recall: seq_addr = `SEQ_LAST_RECAL;
          cmd_as_off: seq_addr = `SEQ_LAST_ASDIS;
          default:    seq_addr = `SEQ_LAST_ASEN;
        endcase
      end
    endcase
  endfunction

  nvsram_bus_cycle u_cycle (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .start    (cyc_start),
    .is_write (cyc_write),
    .use_oe   (cyc_oe),
    .addr     (cyc_addr),
    .wdata    (cyc_wdata),
    .dq_in    (dq_in),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .addr_pin (addr_pin),
    .ce_n     (ce_n),
    .we_n     (we_n),
    .oe_n     (oe_n),
    .dq_out   (dq_out),
    .dq_oe    (dq_oe)
  );

  // decode of where the current command stands
  assign hold_on   = (wait_cnt != 23'h000000);
  assign hold_end  = (wait_cnt == 23'h000001);
  assign step_done = !hold_on && in_flight && cyc_done;
  assign seq_final = step_done && in_seq && (step == 3'h5);
  assign seq_next  = step_done && in_seq && (step != 3'h5);
  assign plain_cmd = (cmd == cmd_read) || (cmd == cmd_write);
  // one access at a time, so no foreign cycle can break a sequence
  assign take      = !hold_on && !in_flight && req && !busy;

  // latch what the accepted request asks for; held for the whole command
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cur_cmd   <= 3'h0;
      cyc_oe    <= 1'b1;
      cyc_wdata <= 8'h00;
      cyc_write <= 1'b0;
    end else if (clk_en && take) begin
      cur_cmd   <= cmd;
      cyc_oe    <= use_oe;              // either read style is a valid step
      cyc_wdata <= wdata;
      // sequence steps are reads, write strobe stays high
      cyc_write <= (cmd == cmd_write);
    end
  end

  // cycle launcher: first cycle on take, sequence steps back to back
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cyc_start <= 1'b0;
      cyc_addr  <= 15'h0000;
      in_flight <= 1'b0;
    end else if (clk_en) begin
      cyc_start <= 1'b0;
      if (take) begin
        // new command: plain address or first sequence address
        cyc_start <= 1'b1;
        in_flight <= 1'b1;
        if (plain_cmd) begin
          cyc_addr <= addr;
        end else begin
          cyc_addr <= {1'b0, seq_addr(3'h0, cmd)};  // top bit unused
        end
      end else if (seq_next) begin
        // next step at once; in_flight stays set so nothing slips
        cyc_start <= 1'b1;
        cyc_addr  <= {1'b0, seq_addr(step + 3'h1, cur_cmd)};
      end else if (step_done) begin
        // last cycle of the command is back
        in_flight <= 1'b0;
      end
    end
  end

  // sequence step counter, counts finished reads 0..5
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      step   <= 3'h0;
      in_seq <= 1'b0;
    end else if (clk_en) begin
      if (take) begin
        // any command restarts the count
        in_seq <= !plain_cmd;
        step   <= 3'h0;
      end else if (seq_next) begin
        step <= step + 3'h1;
      end else if (seq_final) begin
        // six reads done, sequence over
        in_seq <= 1'b0;
      end
    end
  end

  // hold-off after store or recall; the chip ignores access meanwhile
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wait_cnt <= 23'h000000;
    end else if (clk_en) begin
      if (hold_on) begin
        wait_cnt <= wait_cnt - 23'h000001;
      end else if (seq_final && cur_cmd == cmd_store) begin
        // long wait traded for a host that never polls the busy pin
        wait_cnt <= 23'(STORE_WAIT);
      end else if (seq_final && cur_cmd == cmd_recall) begin
        wait_cnt <= 23'(RECALL_WAIT);
      end
    end
  end

  // user handshake: busy from take to ack, ack one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy  <= 1'b0;
      ack   <= 1'b0;
      rdata <= 8'h00;
    end else if (clk_en) begin
      ack <= 1'b0;
      if (take) begin
        busy <= 1'b1;
      end else if (hold_end) begin
        // store or recall time has run out
        busy <= 1'b0;
        ack  <= 1'b1;
      end else if (step_done && !in_seq) begin
        // plain access; rdata only means something after a read
        rdata <= cyc_rdata;
        busy  <= 1'b0;
        ack   <= 1'b1;
      end else if (seq_final && cur_cmd != cmd_store && cur_cmd != cmd_recall) begin
        // autosave commands need no hold-off
        busy <= 1'b0;
        ack  <= 1'b1;
      end
    end
  end

  // autosave setting changed but not yet saved by a manual store
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      autosave_dirty <= 1'b0;
    end else if (clk_en && in_flight && cyc_done && in_seq && step == 3'h5) begin
      if (cur_cmd == cmd_as_off || cur_cmd == cmd_as_on) begin
        autosave_dirty <= 1'b1;
      end else if (cur_cmd == cmd_store) begin
        autosave_dirty <= 1'b0;
      end
    end
  end
endmodule // nvsram_host

// ### nvsram_host_checker.sv
`timescale 1ns/1ps
// watches the host pins during plain cycles and command sequences
module nvsram_host_checker (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        req,
  input wire logic [2:0]  cmd,
  input wire logic        busy,
  input wire logic        ack,
  input wire logic [14:0] addr_pin,
  input wire logic        ce_n,
  input wire logic        we_n,
  input wire logic        dq_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic       in_seq; // sequence command under way
  logic       ce_q;   // chip-select one cycle back
  logic [2:0] n_rd;   // read cycles opened in this sequence
  // track sequence span and count strobe falls since the last ack
  always_ff @(posedge sys_clk) begin
    ce_q <= ce_n;
    if (reset || ack) begin
      in_seq <= 1'b0;
      n_rd   <= 3'h0;
    end else if (req && !busy && cmd >= 3'h2) begin
      in_seq <= 1'b1;
    end else if (ce_q && !ce_n) begin
      n_rd <= n_rd + 3'h1;
    end
  end
  sequence strobe_on;
    $fell(ce_n);
  endsequence
  sequence strobe_off;
    ##[1:8] $rose(ce_n);
  endsequence
  a_read_only_seq: assert property (in_seq |-> we_n)
    else $error("write strobe low inside a sequence");
  a_seq_bus_free: assert property (in_seq |-> !dq_oe)
    else $error("data driven inside a sequence");
  a_cycle_ends: assert property (strobe_on |-> strobe_off)
    else $error("read cycle never ended");
  a_addr_held: assert property (!ce_n && !$past(ce_n) |-> $stable(addr_pin))
    else $error("address moved under chip-select");
  a_six_reads: assert property (in_seq && ack |-> n_rd == 3'h6)
    else $error("sequence did not hold six reads");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
endmodule // nvsram_host_checker
bind nvsram_host nvsram_host_checker chk_u (.sys_clk, .reset, .req, .cmd, .busy, .ack,
  .addr_pin, .ce_n, .we_n, .dq_oe);

// ### nvsram_dev.sv
`timescale 1ns/1ps
`include "nvsram_seq_defines.svh"
// behavioural memory device: array, backup copy and sequence detector
module nvsram_dev #(
  parameter int BUSY = 8
) (
  input  wire logic        sys_clk,
  input  wire logic [14:0] addr_pin,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [7:0]  dq_out,
  output logic [7:0]       dq_in
);
  localparam logic [13:0] PRE [5] = '{`SEQ_ADDR_0, `SEQ_ADDR_1, `SEQ_ADDR_2,
    `SEQ_ADDR_3, `SEQ_ADDR_4};
  logic [7:0]  mem [32768] = '{default: 8'h00}; // sram array
  logic [7:0]  nv [32768] = '{default: 8'h00};  // backup copy
  logic        as_en = 1'b1; // auto save shipped on
  int          step = 0;     // prefix reads matched
  int          blk = 0;      // busy cycles left
  logic        ce_q = 1'b1;
  logic        we_q = 1'b1;
  logic        supply_ok = 1'b1; // no brown-out modelled; gates writes and stores
  logic        wr_armed = 1'b0;  // write taken only once a strobe fall has been seen; never cleared
  logic [14:0] a_q;
  logic [7:0]  d_q;
  logic [7:0]  last = 8'h00; // released bus shows its inverse
  logic        drive;
  wire  [13:0] low = addr_pin[13:0];
  // no output when deselected, writing, busy or on a sixth store/recall read
  assign drive = !ce_n && we_n && !oe_n && blk == 0 && !(step == 5 &&
    (low == `SEQ_LAST_STORE || low == `SEQ_LAST_RECAL));
  assign dq_in = drive ? mem[addr_pin] : ~last;
  // cycles are judged when chip-select rises
  always @(posedge sys_clk) begin
    if (drive)
      last <= dq_in;
    ce_q <= ce_n;
    we_q <= we_n;
    a_q <= addr_pin;
    d_q <= dq_out;
    if ((ce_q && !ce_n) || (we_q && !we_n))
      wr_armed <= 1'b1;
    if (blk > 0) begin
      blk <= blk - 1; // accesses ignored meanwhile
    end else if (!ce_q && ce_n && !we_q) begin
      if (wr_armed && supply_ok)
        mem[a_q] = d_q;
      step <= 0;
    end else if (!ce_q && ce_n) begin
      if (step < 5 && a_q[13:0] == PRE[step]) begin
        step <= step + 1; // either strobe style counts
      end else begin
        step <= (a_q[13:0] == PRE[0]) ? 1 : 0;
        if (step == 5) begin
          case (a_q[13:0])
            `SEQ_LAST_STORE: begin
              if (supply_ok)
                nv = mem;
              blk <= BUSY;
            end
            `SEQ_LAST_RECAL: begin // clear then copy, backup untouched
              foreach (mem[i]) mem[i] = 8'h00;
              mem = nv;
              blk <= BUSY;
            end
            `SEQ_LAST_ASDIS: as_en <= 1'b0;
            `SEQ_LAST_ASEN: as_en <= 1'b1;
            default: ;
          endcase
        end
      end
    end
  end
endmodule // nvsram_dev

// ### tb_top.sv
`timescale 1ns/1ps
// host controller against the device model
module tb_top;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        req = 1'b0;
  logic        use_oe = 1'b1;
  logic [2:0]  cmd = 3'h0;
  logic [14:0] addr = 15'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        busy, ack, autosave_dirty, ce_n, we_n, oe_n, dq_oe;
  logic [7:0]  rdata, dq_out, dq_in;
  logic [14:0] addr_pin;
  logic [7:0]  exp_q [$]; // expected read bytes, oldest first
  int          miscompares = 0;
  int          n_compared = 0;
  nvsram_host #(.STORE_WAIT(10), .RECALL_WAIT(10)) dut_u (.sys_clk, .reset, .clk_en(1'b1),
    .req, .cmd, .addr, .wdata, .use_oe, .busy, .ack, .rdata, .autosave_dirty, .addr_pin,
    .ce_n, .we_n, .oe_n, .dq_out, .dq_oe, .dq_in);
  nvsram_dev part_u (.sys_clk, .addr_pin, .ce_n, .we_n, .oe_n, .dq_out, .dq_in);
  initial forever #25 sys_clk = ~sys_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one request, dropped once taken, then bounded wait for ack
  task automatic op(input logic [2:0] c, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= 1'b1;
    cmd <= c;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
    check(8'(busy), 8'h01);
    do @(posedge sys_clk); while (ack !== 1'b1 && ++n < 500);
    check(8'(busy), 8'h00);
    if (n >= 500) begin
      miscompares++;
      $display("Error at %0t: no acknowledge", $time);
    end
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    op(3'h0, a, 8'h00);
  endtask
  // result side: a read ack retires the oldest note
  always @(posedge sys_clk)
    if (ack === 1'b1 && cmd == 3'h0 && exp_q.size() > 0)
      check(rdata, exp_q.pop_front());
  initial begin
    logic [14:0] a;
    logic [7:0]  d;
    void'($urandom(45146));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      a = 15'($urandom);
      d = 8'($urandom);
      op(3'h1, a, d);
      rd(a, d);
    end
    $display("test plain access done");
    // store, overwrite, recall twice; strobe style alternates
    for (int i = 0; i < 3; i++) begin
      a = 15'($urandom);
      d = 8'($urandom);
      op(3'h1, a, d);
      use_oe <= i[0];
      op(3'h2, 15'h0000, 8'h00);
      use_oe <= 1'b1;
      op(3'h1, a, ~d);
      rd(a, ~d);
      use_oe <= ~i[0];
      op(3'h3, 15'h0000, 8'h00);
      op(3'h3, 15'h0000, 8'h00);
      use_oe <= 1'b1;
      rd(a, d);
    end
    $display("test store recall done");
    check(8'(part_u.as_en), 8'h01);
    op(3'h4, 15'h0000, 8'h00);
    check(8'(part_u.as_en), 8'h00);
    check(8'(autosave_dirty), 8'h01);
    op(3'h5, 15'h0000, 8'h00);
    check(8'(part_u.as_en), 8'h01);
    op(3'h2, 15'h0000, 8'h00);
    check(8'(autosave_dirty), 8'h00);
    $display("test auto save done");
    complete_run();
  end
  // about 1000 cycles expected; twenty times that is a hang
  initial begin
    #(20000 * 50);
    miscompares++;
    complete_run();
  end
endmodule // tb_top
